// ---- shared/lrzp_pkg.sv ----
package lrzp_pkg;

  localparam int CA_W = 10;
  localparam int MA_W = 8;
  localparam logic [7:0] MA_RESET = 8'h3f;
  localparam logic [7:0] MA_ZQ = 8'h0a;
  localparam logic [7:0] ZQ_INIT_OP = 8'hff;
  localparam logic [7:0] ZQ_LONG_OP = 8'hab;
  localparam logic [7:0] ZQ_SHORT_OP = 8'h56;
  localparam logic [7:0] ZQ_RESET_OP = 8'hc3;
  localparam int CLK_NS = 100;
  localparam int T_INIT4_NS = 1000;
  localparam int T_ZQINIT_NS = 1000000;
  localparam int T_ZQCL_NS = 360;
  localparam int T_ZQCS_NS = 90;
  localparam int T_ZQRESET_NS = 50;
  localparam int T_CKE_CK = 3;
  localparam int T_XP_NS = 200;
  localparam int T_INIT4_CK = (T_INIT4_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ZQINIT_CK = (T_ZQINIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ZQCL_CK = (T_ZQCL_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ZQCS_CK = (T_ZQCS_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ZQRESET_CK = (T_ZQRESET_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_XP_CK = (T_XP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 16;

  typedef enum {
    LRZP_IDLE,
    LRZP_RESETTING,
    LRZP_ZQ_BUSY,
    LRZP_PD,
    LRZP_PD_EXIT
  } lrzp_state_e;

  typedef struct packed {
    logic cs_n;
    logic [CA_W-1:0] ca_r;
    logic [CA_W-1:0] ca_f;
  } lrzp_cmd_s;

  typedef struct packed {
    logic mrw_reset;
    logic zq_init;
    logic zq_long;
    logic zq_short;
    logic zq_reset;
  } lrzp_evt_s;

endpackage : lrzp_pkg

// ---- hdl/lrzp_ctrl.sv ----
module lrzp_ctrl #(
  parameter int ZQINIT_CK = lrzp_pkg::T_ZQINIT_CK, // Init calibration cycles.
  parameter int INIT4_CK = lrzp_pkg::T_INIT4_CK // Reset period cycles.
) (
  input wire logic clk_i, // 10 MHz clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic ce_i, // Clock enable for all state.
  input wire logic cke_i, // Memory clock enable pin.
  input wire logic cs_n_i, // Chip select pin, active low.
  input wire logic [lrzp_pkg::CA_W-1:0] ca_r_i, // Rising-edge command/address.
  input wire logic [lrzp_pkg::CA_W-1:0] ca_f_i, // Falling-edge command/address.
  input wire logic zq_tied_i, // Calibration pin tied to supply.
  input wire logic banks_open_i, // Any bank holds an open row.
  output logic busy_o, // Reset or calibration period running.
  output logic resetting_o, // Auto-initialization resetting.
  output logic mr_default_o, // One-cycle pulse: restore mode register defaults.
  output logic array_invalid_o, // Array contents undefined.
  output logic [1:0] zq_mode_o, // Current calibration: 0 init 1 long 2 short 3 reset.
  output logic zq_calibrated_o, // Driver uses calibrated settings.
  output logic pd_o, // In power-down.
  output logic pd_active_o, // Active power-down.
  output logic buf_en_o, // Input/output buffers enabled.
  output logic cmd_ok_o, // Commands may be accepted.
  output logic viol_o // Sticky: non-no-op during busy or exit latency.
);

  // Refuses busy counts that the counter cannot hold.
  if (ZQINIT_CK < 1 || INIT4_CK < 1 ||
      ZQINIT_CK >= 65536 || INIT4_CK >= 65536) begin : g_bad_count
    $error("lrzp_ctrl: busy counts must fit the counter");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [1:0] cke_s;
  logic [1:0] cs_s;
  logic [2*lrzp_pkg::CA_W-1:0] ca_s0;
  logic [2*lrzp_pkg::CA_W-1:0] ca_s1;
  logic [1:0] zq_s;
  logic [1:0] bank_s;
  logic cke_prev;
  logic [1:0] next_cke_s;
  logic [1:0] next_cs_s;
  logic [2*lrzp_pkg::CA_W-1:0] next_ca_s0;
  logic [2*lrzp_pkg::CA_W-1:0] next_ca_s1;
  logic [1:0] next_zq_s;
  logic [1:0] next_bank_s;
  logic next_cke_prev;

  // Two-stage capture of every pin; the second stage alone feeds logic.
  always_comb begin
    next_cke_s = {cke_s[0], cke_i};
    next_cs_s = {cs_s[0], cs_n_i};
    next_ca_s0 = {ca_r_i, ca_f_i};
    next_ca_s1 = ca_s0;
    next_zq_s = {zq_s[0], zq_tied_i};
    next_bank_s = {bank_s[0], banks_open_i};
    next_cke_prev = cke_s[1];
  end

  // Registers the synchronisers.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cke_s <= 2'h0;
      cs_s <= 2'h3;
      ca_s0 <= '0;
      ca_s1 <= '0;
      zq_s <= 2'h0;
      bank_s <= 2'h0;
      cke_prev <= 1'b0;
    end else if (ce_i) begin
      cke_s <= next_cke_s;
      cs_s <= next_cs_s;
      ca_s0 <= next_ca_s0;
      ca_s1 <= next_ca_s1;
      zq_s <= next_zq_s;
      bank_s <= next_bank_s;
      cke_prev <= next_cke_prev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command decode.
  lrzp_pkg::lrzp_cmd_s cmd;
  logic is_nop;
  logic is_mrw;
  logic [lrzp_pkg::MA_W-1:0] ma;
  logic [7:0] op;
  lrzp_pkg::lrzp_evt_s evt;

  // Decodes the sampled command and its mode register fields.
  always_comb begin
    cmd = '{cs_n: cs_s[1], ca_r: ca_s1[2*lrzp_pkg::CA_W-1:lrzp_pkg::CA_W],
            ca_f: ca_s1[lrzp_pkg::CA_W-1:0]};
    is_nop = cmd.cs_n || (cmd.ca_r[2:0] == 3'h7);
    is_mrw = !cmd.cs_n && (cmd.ca_r[3:0] == 4'h0) && cke_s[1] && cke_prev;
    ma = {cmd.ca_f[1:0], cmd.ca_r[9:4]};
    op = cmd.ca_f[9:2];
    evt.mrw_reset = is_mrw && (ma == lrzp_pkg::MA_RESET);
    evt.zq_init = is_mrw && (ma == lrzp_pkg::MA_ZQ) && (op == lrzp_pkg::ZQ_INIT_OP) && !zq_s[1];
    evt.zq_long = is_mrw && (ma == lrzp_pkg::MA_ZQ) && (op == lrzp_pkg::ZQ_LONG_OP) && !zq_s[1];
    evt.zq_short = is_mrw && (ma == lrzp_pkg::MA_ZQ) && (op == lrzp_pkg::ZQ_SHORT_OP) && !zq_s[1];
    evt.zq_reset = is_mrw && (ma == lrzp_pkg::MA_ZQ) && (op == lrzp_pkg::ZQ_RESET_OP) && !zq_s[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main state machine.
  lrzp_pkg::lrzp_state_e state;
  lrzp_pkg::lrzp_state_e next_state;
  logic [lrzp_pkg::CNT_W-1:0] cnt;
  logic [lrzp_pkg::CNT_W-1:0] next_cnt;
  logic [1:0] zq_mode;
  logic [1:0] next_zq_mode;
  logic calibrated;
  logic next_calibrated;
  logic mr_pulse;
  logic next_mr_pulse;
  logic arr_bad;
  logic next_arr_bad;
  logic pd_act;
  logic next_pd_act;
  logic viol;
  logic next_viol;

  // Computes next state, busy counter and flags.
  always_comb begin
    next_state = state;
    next_cnt = (cnt != '0) ? cnt - 1'b1 : cnt;
    next_zq_mode = zq_mode;
    next_calibrated = calibrated && !zq_s[1];
    next_mr_pulse = 1'b0;
    next_arr_bad = arr_bad;
    next_pd_act = pd_act;
    next_viol = viol;
    case (state)
      lrzp_pkg::LRZP_IDLE: begin
        if (cke_prev && !cke_s[1] && cmd.cs_n) begin
          next_state = lrzp_pkg::LRZP_PD;
          next_pd_act = bank_s[1];
        end else if (evt.mrw_reset) begin
          next_state = lrzp_pkg::LRZP_RESETTING;
          next_mr_pulse = 1'b1;
          next_arr_bad = 1'b1;
          next_calibrated = 1'b0;
          next_cnt = lrzp_pkg::CNT_W'(INIT4_CK);
        end else if (evt.zq_init) begin
          next_state = lrzp_pkg::LRZP_ZQ_BUSY;
          next_zq_mode = 2'h0;
          next_cnt = lrzp_pkg::CNT_W'(ZQINIT_CK);
        end else if (evt.zq_long) begin
          next_state = lrzp_pkg::LRZP_ZQ_BUSY;
          next_zq_mode = 2'h1;
          next_cnt = lrzp_pkg::CNT_W'(lrzp_pkg::T_ZQCL_CK);
        end else if (evt.zq_short) begin
          next_state = lrzp_pkg::LRZP_ZQ_BUSY;
          next_zq_mode = 2'h2;
          next_cnt = lrzp_pkg::CNT_W'(lrzp_pkg::T_ZQCS_CK);
        end else if (evt.zq_reset) begin
          next_state = lrzp_pkg::LRZP_ZQ_BUSY;
          next_zq_mode = 2'h3;
          next_cnt = lrzp_pkg::CNT_W'(lrzp_pkg::T_ZQRESET_CK);
        end
      end
      lrzp_pkg::LRZP_RESETTING, lrzp_pkg::LRZP_ZQ_BUSY: begin
        if (!is_nop) begin
          next_viol = 1'b1;
        end
        if (cnt == 16'h0001) begin
          next_state = lrzp_pkg::LRZP_IDLE;
          if (state == lrzp_pkg::LRZP_ZQ_BUSY) begin
            next_calibrated = (zq_mode != 2'h3) && !zq_s[1];
          end
        end
      end
      // Nothing runs while powered down, except that a tied calibration pin still clears calibration; the exit is watched.
      lrzp_pkg::LRZP_PD: begin
        if (cke_s[1]) begin
          next_state = lrzp_pkg::LRZP_PD_EXIT;
          next_cnt = lrzp_pkg::CNT_W'(lrzp_pkg::T_XP_CK);
        end
      end
      lrzp_pkg::LRZP_PD_EXIT: begin
        if (!is_nop) begin
          next_viol = 1'b1;
        end
        if (cnt == 16'h0001) begin
          next_state = lrzp_pkg::LRZP_IDLE;
          next_pd_act = 1'b0;
        end
      end
      default: begin
        next_state = lrzp_pkg::LRZP_IDLE;
      end
    endcase
  end

  // Registers the state machine.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= lrzp_pkg::LRZP_IDLE;
      cnt <= '0;
      zq_mode <= 2'h0;
      calibrated <= 1'b0;
      mr_pulse <= 1'b0;
      arr_bad <= 1'b0;
      pd_act <= 1'b0;
      viol <= 1'b0;
    end else if (ce_i) begin
      state <= next_state;
      cnt <= next_cnt;
      zq_mode <= next_zq_mode;
      calibrated <= next_calibrated;
      mr_pulse <= next_mr_pulse;
      arr_bad <= next_arr_bad;
      pd_act <= next_pd_act;
      viol <= next_viol;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs.
  logic [10:0] next_out;
  logic [10:0] out_q;

  // Derives the output bundle from the next state so outputs stay registered.
  always_comb begin
    next_out = {next_state == lrzp_pkg::LRZP_RESETTING || next_state == lrzp_pkg::LRZP_ZQ_BUSY,
                next_state == lrzp_pkg::LRZP_RESETTING, next_mr_pulse, next_arr_bad,
                next_zq_mode, next_calibrated, next_state == lrzp_pkg::LRZP_PD,
                next_state == lrzp_pkg::LRZP_PD && next_pd_act,
                next_state != lrzp_pkg::LRZP_PD,
                next_state == lrzp_pkg::LRZP_IDLE};
  end

  // Registers the output bundle.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      out_q <= 11'h003;
    end else if (ce_i) begin
      out_q <= next_out;
    end
  end

  assign {busy_o, resetting_o, mr_default_o, array_invalid_o, zq_mode_o, zq_calibrated_o,
          pd_o, pd_active_o, buf_en_o, cmd_ok_o} = out_q;
  assign viol_o = viol;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence reset_seen_s;
    evt.mrw_reset && state == lrzp_pkg::LRZP_IDLE && !(cke_prev && !cke_s[1] && cmd.cs_n);
  endsequence

  sequence resetting_s;
    state == lrzp_pkg::LRZP_RESETTING;
  endsequence

  sequence pd_entry_s;
    state == lrzp_pkg::LRZP_IDLE && cke_prev && !cke_s[1] && cmd.cs_n;
  endsequence

  // A reset write enters resetting with a one-cycle default restore and the array flag.
  reset_enters_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    reset_seen_s |=> resetting_s) else $error("reset write did not enter resetting");
  mr_default_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    reset_seen_s |=> mr_default_o && array_invalid_o) else $error("no default restore");
  mr_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    mr_default_o |=> !mr_default_o) else $error("default restore pulse too long");

  // Once undefined, the array stays undefined until the block is reset.
  array_undef_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    array_invalid_o |=> array_invalid_o) else $error("array flag cleared");

  // A short calibration loads its own busy count.
  zq_short_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    state == lrzp_pkg::LRZP_IDLE && evt.zq_short && !(cke_prev && !cke_s[1] && cmd.cs_n)
    |=> state == lrzp_pkg::LRZP_ZQ_BUSY && cnt == 16'(lrzp_pkg::T_ZQCS_CK))
    else $error("short calibration not loaded");

  // A tied calibration pin keeps an idle device out of calibration and on defaults.
  zq_tied_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    zq_s[1] && state == lrzp_pkg::LRZP_IDLE
    |=> state != lrzp_pkg::LRZP_ZQ_BUSY && !zq_calibrated_o)
    else $error("calibration accepted with pin tied");

  // Entry, kind and quiet inputs of power-down.
  pd_entry_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    pd_entry_s |=> state == lrzp_pkg::LRZP_PD && pd_o) else $error("power-down not entered");
  pd_kind_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pd_o && !$past(pd_o) |-> pd_active_o == $past(bank_s[1]))
    else $error("power-down kind wrong");
  pd_buf_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pd_o |-> !buf_en_o && !cmd_ok_o) else $error("buffers on in power-down");
  pd_ignore_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    state == lrzp_pkg::LRZP_PD && !viol |=> !viol_o) else $error("input seen in power-down");

  // Exit on clock enable high, then the exit latency admits only no-ops.
  pd_exit_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    state == lrzp_pkg::LRZP_PD && cke_s[1] |=> state == lrzp_pkg::LRZP_PD_EXIT)
    else $error("power-down exit missed");
  pd_latency_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    state == lrzp_pkg::LRZP_PD_EXIT && !is_nop |=> viol_o)
    else $error("command inside exit latency not flagged");

  // Any real command inside a busy period raises the sticky flag.
  busy_viol_a: assert property (@(posedge clk_i) disable iff (!reset_n_i || !ce_i)
    (state == lrzp_pkg::LRZP_ZQ_BUSY || state == lrzp_pkg::LRZP_RESETTING) && !is_nop
    |=> viol_o) else $error("busy command not flagged");

endmodule // lrzp_ctrl

// ---- bench/lrzp_host_model.sv ----
module lrzp_host_model (
  input wire logic clk_i, // Bench clock.
  input wire logic send_i, // Issue cmd_i at the next edge.
  input wire lrzp_pkg::lrzp_cmd_s cmd_i, // Command to place on the pins.
  input wire logic cke_req_i, // Wanted clock enable level.
  output logic cke_o, // Clock enable pin.
  output lrzp_pkg::lrzp_cmd_s cmd_o // Chip select and command/address pins.
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////////
  // Commands go out only while clock enable is steady high, so entry, exit and the cycle
  // after entry always carry a deselect no-op; idle address bits toggle every cycle.
  // It drives a single die, so no calibration ever shares the resistor with another.
  initial begin
    cke_o = 1'b1;
    cmd_o = '{cs_n: 1'b1, ca_r: '0, ca_f: '0};
  end
  always @(posedge clk_i) begin
    cke_o <= cke_req_i;
    if (send_i && cke_req_i && cke_o) begin
      cmd_o <= cmd_i;
    end else begin
      cmd_o.cs_n <= 1'b1;
      cmd_o.ca_r <= ~cmd_o.ca_r;
      cmd_o.ca_f <= ~cmd_o.ca_f;
    end
  end
endmodule // lrzp_host_model

// ---- bench/lrzp_ctrl_tb.sv ----
module lrzp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int INIT4 = 4;
  localparam int ZQI = 4;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic send = 1'b0;
  logic cke_req = 1'b1;
  logic zq_tied_i = 1'b0;
  logic banks_open_i = 1'b0;
  logic ce = 1'b1;
  lrzp_pkg::lrzp_cmd_s cmd = '{cs_n: 1'b1, ca_r: '0, ca_f: '0};
  logic cke;
  lrzp_pkg::lrzp_cmd_s pins;
  logic busy_o, resetting_o, mr_default_o, array_invalid_o, zq_calibrated_o;
  logic pd_o, pd_active_o, buf_en_o, cmd_ok_o, viol_o;
  logic [1:0] zq_mode_o;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_default = 0;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and the pulse counter for mode register defaults.
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (mr_default_o === 1'b1) n_default <= n_default + 1;
    if (cycles == 5000) begin
      num_errors++;
      results();
    end
  end

  lrzp_host_model i_host (.clk_i(clk_i), .send_i(send), .cmd_i(cmd), .cke_req_i(cke_req),
    .cke_o(cke), .cmd_o(pins));

  lrzp_ctrl #(.ZQINIT_CK(ZQI), .INIT4_CK(INIT4)) i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .ce_i(ce), .cke_i(cke), .cs_n_i(pins.cs_n), .ca_r_i(pins.ca_r), .ca_f_i(pins.ca_f),
    .zq_tied_i(zq_tied_i), .banks_open_i(banks_open_i), .busy_o(busy_o),
    .resetting_o(resetting_o), .mr_default_o(mr_default_o), .array_invalid_o(array_invalid_o),
    .zq_mode_o(zq_mode_o), .zq_calibrated_o(zq_calibrated_o), .pd_o(pd_o),
    .pd_active_o(pd_active_o), .buf_en_o(buf_en_o), .cmd_ok_o(cmd_ok_o), .viol_o(viol_o));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks: compare, verdict, settle, issue a mode register write, time a busy period.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
    @(posedge clk_i);
    cmd <= '{cs_n: 1'b0, ca_r: {ma[5:0], 4'h0}, ca_f: {op, ma[7:6]}};
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    #1;
  endtask

  // Waits up to 8 cycles for busy to start, then checks that it lasts exactly the expected count.
  task automatic busy_len(input int exp, input string what);
    int n;
    n = 0;
    while (busy_o !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    n = 0;
    while (busy_o === 1'b1 && n < 20000) begin
      tick(1);
      n++;
    end
    check(n, exp, what);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic t_reset_values();
    check({busy_o, resetting_o, mr_default_o, array_invalid_o, zq_mode_o, zq_calibrated_o,
      pd_o, pd_active_o, viol_o}, 0, "reset low");
    check({buf_en_o, cmd_ok_o}, 2'b11, "reset high");
  endtask

  task automatic t_zq_codes();
    logic [7:0] ops [4];
    int lens [4];
    ops = '{lrzp_pkg::ZQ_INIT_OP, lrzp_pkg::ZQ_LONG_OP, lrzp_pkg::ZQ_SHORT_OP,
      lrzp_pkg::ZQ_RESET_OP};
    lens = '{ZQI, lrzp_pkg::T_ZQCL_CK, lrzp_pkg::T_ZQCS_CK, lrzp_pkg::T_ZQRESET_CK};
    for (int i = 0; i < 4; i++) begin
      mrw(lrzp_pkg::MA_ZQ, ops[i]);
      busy_len(lens[i], "zq busy length");
      tick(2);
      check(zq_mode_o, i, "zq mode");
      check(zq_calibrated_o, i != 3, "zq calibrated");
      check(cmd_ok_o, 1, "idle after zq");
    end
  endtask

  task automatic t_zq_tied();
    mrw(lrzp_pkg::MA_ZQ, lrzp_pkg::ZQ_LONG_OP);
    busy_len(lrzp_pkg::T_ZQCL_CK, "zq long again");
    tick(2);
    @(posedge clk_i);
    zq_tied_i <= 1'b1;
    tick(6);
    check(zq_calibrated_o, 0, "tied clears calibration");
    mrw(lrzp_pkg::MA_ZQ, lrzp_pkg::ZQ_SHORT_OP);
    busy_len(0, "tied ignores zq");
    check(zq_calibrated_o, 0, "tied keeps defaults");
    check(zq_mode_o, 1, "tied keeps last mode");
    @(posedge clk_i);
    zq_tied_i <= 1'b0;
    tick(4);
  endtask

  task automatic t_mrw_reset();
    int d0;
    d0 = n_default;
    mrw(lrzp_pkg::MA_RESET, 8'h5a);
    tick(4);
    check(resetting_o, 1, "resetting");
    busy_len(INIT4 - 1, "reset period");
    check(n_default - d0, 1, "defaults pulse");
    check(array_invalid_o, 1, "array undefined");
    tick(3);
    check(array_invalid_o, 1, "array undefined stays");
  endtask

  task automatic t_power_down();
    for (int b = 0; b < 2; b++) begin
      @(posedge clk_i);
      banks_open_i <= b[0];
      tick(4);
      cke_req <= 1'b0;
      tick(6);
      check(pd_o, 1, "pd entry");
      check(pd_active_o, b, "pd kind");
      check({buf_en_o, cmd_ok_o}, 0, "buffers off");
      cke_req <= 1'b1;
      tick(5);
      check({pd_o, buf_en_o}, 2'b01, "pd exit");
      tick(lrzp_pkg::T_XP_CK + 2);
      check(cmd_ok_o, 1, "ready after exit");
    end
    check(viol_o, 0, "no violation yet");
    @(posedge clk_i);
    banks_open_i <= 1'b0;
  endtask

  // A low clock enable freezes a running busy count, which resumes where it stopped.
  task automatic t_freeze();
    mrw(lrzp_pkg::MA_ZQ, lrzp_pkg::ZQ_LONG_OP);
    tick(3);
    check(busy_o, 1, "long busy started");
    @(posedge clk_i);
    ce <= 1'b0;
    tick(6);
    check(busy_o, 1, "busy frozen while disabled");
    @(posedge clk_i);
    ce <= 1'b1;
    busy_len(lrzp_pkg::T_ZQCL_CK - 1, "busy resumes after freeze");
    check(viol_o, 0, "no flag while frozen");
  endtask

  task automatic t_violation();
    mrw(lrzp_pkg::MA_ZQ, lrzp_pkg::ZQ_LONG_OP);
    mrw(lrzp_pkg::MA_ZQ, lrzp_pkg::ZQ_SHORT_OP);
    tick(10);
    check(viol_o, 1, "command during busy flagged");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    tick(5);
    t_reset_values();
    @(posedge clk_i);
    reset_n_i <= 1'b1;
    tick(2);
    t_zq_codes();
    t_zq_tied();
    t_mrw_reset();
    t_power_down();
    t_freeze();
    t_violation();
    results();
  end
endmodule // lrzp_ctrl_tb
